// [asfcs_baud.sv]
// Sample tick at sixteen times the bit rate, internal divider or external clock
module asfcs_baud (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic extSel,
	input wire logic extSerClk,
	input wire logic [15:0] divisor,
	output logic tick
);
	typedef struct packed {
		logic [15:0] cnt;
		logic extPrev;
		logic tick;
	} asfcs_baud_st_t;
	asfcs_baud_st_t state_ff, nxt_state;

	always_comb begin
		nxt_state = state_ff;
		nxt_state.extPrev = extSerClk;
		nxt_state.tick = 1'b0;
		if (extSel) begin
			// Both edges of an 8x clock give the 16 samples per bit
			nxt_state.tick = (extSerClk != state_ff.extPrev);
			nxt_state.cnt = '0;
		end else if (state_ff.cnt >= divisor) begin
			nxt_state.cnt = '0;
			nxt_state.tick = 1'b1;
		end else begin
			nxt_state.cnt = state_ff.cnt + 16'h0001;
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign tick = state_ff.tick;
endmodule

// [asfcs_fifo.sv]
// Byte FIFO with occupancy count
module asfcs_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 64
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic clear,
	input wire logic push,
	input wire logic [WIDTH-1:0] wrData,
	input wire logic pop,
	output logic [WIDTH-1:0] rdData,
	output logic [$clog2(DEPTH):0] count,
	output logic full,
	output logic empty
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wrPtr;
		logic [AW-1:0] rdPtr;
		logic [AW:0] count;
	} asfcs_fifo_st_t;
	asfcs_fifo_st_t state_ff, nxt_state;
	logic doPush, doPop;

	always_comb begin
		nxt_state = state_ff;
		doPush = push && !full;
		doPop = pop && !empty;
		if (doPush) begin
			nxt_state.mem[state_ff.wrPtr] = wrData;
			nxt_state.wrPtr = state_ff.wrPtr + 1'b1;
		end
		if (doPop) begin
			nxt_state.rdPtr = state_ff.rdPtr + 1'b1;
		end
		// Count moves at the end of the cycle of a lone push or pop; a push with a pop leaves it
		if (doPush && !doPop) begin
			nxt_state.count = state_ff.count + 1'b1;
		end else if (doPop && !doPush) begin
			nxt_state.count = state_ff.count - 1'b1;
		end
		if (clear) begin
			nxt_state.wrPtr = '0;
			nxt_state.rdPtr = '0;
			nxt_state.count = '0;
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign rdData = state_ff.mem[state_ff.rdPtr];
	assign count = state_ff.count;
	assign full = (state_ff.count == (AW+1)'(DEPTH));
	assign empty = (state_ff.count == '0);
endmodule

// [asfcs_map.svh]
// Register map, field positions, reset values and timing counts of the serial unit
// Operation
// - Fill count bits 14:8 show bytes waiting in the transmit FIFO.
// - Fill count bits 6:0 show bytes held in the receive FIFO.
// - Transmit count reads zero when empty and 0x40 when full.
// - Receive count reads zero when empty and 0x40 when full.
// - Fill count bits 15 and 7 read zero; register is read-only, resets zero.
// - Stop count only matters while the stop function is enabled.
// - Stop count value N means N plus one bytes.
// - With stop enabled, transmitter halts after the programmed bytes are fully sent.
// - Stop count register resets to 0xFF and is read/write.
// - Separate 64-byte transmit and receive FIFOs allow back-to-back characters.
// - Mode bit 6 selects eight data bits (0) or seven (1).
// - Mode bit 5 adds one parity bit per frame; no multiprocessor bit.
// - Mode bit 3 selects one stop bit (0) or two (1).
// - Receiver flags framing, parity, overrun, FIFO full, data ready and break.
// - Frame is low start, data LSB first, optional parity, high stops, then high.
// - On reaching the stop count, stop sending, set flag, interrupt if enabled.
// - With two stop bits only the first one is checked for framing.
`ifndef ASFCS_MAP_SVH
`define ASFCS_MAP_SVH

`define ASFCS_OFS_MODE 8'h00
`define ASFCS_OFS_CTRL 8'h04
`define ASFCS_OFS_STATUS 8'h08
`define ASFCS_OFS_MASK 8'h0C
`define ASFCS_OFS_TXDATA 8'h10
`define ASFCS_OFS_RXDATA 8'h14
`define ASFCS_OFS_FILL 8'h18
`define ASFCS_OFS_STOPCNT 8'h1C
`define ASFCS_OFS_BAUD 8'h20

`define ASFCS_MODE_CHAR7 6
`define ASFCS_MODE_PAREN 5
`define ASFCS_MODE_PARODD 4
`define ASFCS_MODE_STOP2 3

`define ASFCS_CTRL_TXEN 0
`define ASFCS_CTRL_RXEN 1
`define ASFCS_CTRL_TXCLR 2
`define ASFCS_CTRL_RXCLR 3
`define ASFCS_CTRL_STOPEN 4
`define ASFCS_CTRL_EXTCLK 5
`define ASFCS_CTRL_LOOP 6

`define ASFCS_ST_TXSTOP 0
`define ASFCS_ST_FRAME 1
`define ASFCS_ST_PARITY 2
`define ASFCS_ST_OVERRUN 3
`define ASFCS_ST_RXFULL 4
`define ASFCS_ST_RXREADY 5
`define ASFCS_ST_BREAK 6
`define ASFCS_ST_TXDONE 7

`define ASFCS_RST_MODE 8'h00
`define ASFCS_RST_CTRL 7'h00
`define ASFCS_RST_STOPCNT 8'hFF
`define ASFCS_RST_BAUD 16'h000A

`define ASFCS_TICKS_LAST 4'hF
`define ASFCS_TICKS_MID 4'h7

`endif

// [asfcs_pkg.sv]
// Shared types of the serial unit
package asfcs_pkg;
	typedef enum logic [4:0] {
		SER_IDLE = 5'h01,
		SER_START = 5'h02,
		SER_DATA = 5'h04,
		SER_PARITY = 5'h08,
		SER_STOP = 5'h10
	} asfcs_ser_state_t;
endpackage

// [asfcs_remote.sv]
// Remote serial device: decodes the transmit line and drives the receive line
module asfcs_remote (
	input wire logic ref_clk,
	input wire logic txd,
	input wire logic char7,
	input wire logic parEn,
	input wire logic stop2,
	output logic rxd
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int BIT = 16;
	logic [9:0] got[$];
	logic [7:0] v;
	logic p;
	logic s;
	initial rxd = 1'b1;
	// Samples each bit mid-cell: start low, data LSB first, parity, stops
	always begin
		@(negedge txd);
		repeat (BIT / 2) @(posedge ref_clk);
		if (txd === 1'b0) begin
			v = 8'h00;
			for (int i = 0; i < (char7 ? 7 : 8); i++) begin
				repeat (BIT) @(posedge ref_clk);
				v[i] = txd;
			end
			p = 1'b0;
			if (parEn) begin
				repeat (BIT) @(posedge ref_clk);
				p = txd;
			end
			repeat (BIT) @(posedge ref_clk);
			s = txd;
			// Second stop cell must also be high
			if (stop2) begin
				repeat (BIT) @(posedge ref_clk);
				s = s & txd;
			end
			got.push_back({s, p, v});
		end
	end
	// 8-bit frame toward the unit, stop low on request, line back to idle high
	task automatic send(input logic [7:0] d, input logic badStop);
		logic [9:0] f;
		f = {~badStop, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd <= f[i];
			repeat (BIT) @(posedge ref_clk);
		end
		rxd <= 1'b1;
		repeat (2) @(posedge ref_clk);
	endtask
endmodule

// [asfcs_uart.sv]
// Asynchronous serial unit with FIFO fill counts and transmit stop count, APB slave
`include "asfcs_map.svh"
module asfcs_uart #(
	parameter int FIFO_DEPTH = 64
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rxd,
	input wire logic extSerClk,
	output logic txd,
	output logic irq
);
	localparam int CW = $clog2(FIFO_DEPTH) + 1;

	typedef struct packed {
		logic [7:0] mode;
		logic [6:0] ctrl;
		logic [7:0] status;
		logic [7:0] mask;
		logic [7:0] stopCnt;
		logic [15:0] baudDiv;
		logic [31:0] rdata;
		asfcs_pkg::asfcs_ser_state_t txState;
		logic [3:0] txTick;
		logic [2:0] txBit;
		logic [7:0] txShift;
		logic txPar;
		logic txLine;
		logic [7:0] txSent;
		asfcs_pkg::asfcs_ser_state_t rxState;
		logic [3:0] rxTick;
		logic [2:0] rxBit;
		logic [7:0] rxShift;
		logic rxAcc;
		logic rxZero;
		logic rxParBad;
	} asfcs_uart_st_t;
	asfcs_uart_st_t state_ff, nxt_state;

	logic [CW-1:0] txCount, rxCount;
	logic txFull, txEmpty, rxFull, rxEmpty, tick;
	logic [7:0] txHead, rxHead, rxByte, evt, clr;
	logic txPush, txPop, rxPush, rxPop;
	logic accWr, accRd, setupRd, addrOk, rxLine, txHalt;
	logic char7, parEn, parOdd, stop2, txEn, rxEn, stopEn;
	logic [2:0] lastBit;
	logic [31:0] rdVal;
	logic [15:0] fillVal;

	// Separate transmit and receive storage
	asfcs_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) txFifo (
		.ref_clk(ref_clk),
		.reset(reset),
		.clear(state_ff.ctrl[`ASFCS_CTRL_TXCLR]),
		.push(txPush),
		.wrData(pwdata[7:0]),
		.pop(txPop),
		.rdData(txHead),
		.count(txCount),
		.full(txFull),
		.empty(txEmpty)
	);

	asfcs_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) rxFifo (
		.ref_clk(ref_clk),
		.reset(reset),
		.clear(state_ff.ctrl[`ASFCS_CTRL_RXCLR]),
		.push(rxPush),
		.wrData(rxByte),
		.pop(rxPop),
		.rdData(rxHead),
		.count(rxCount),
		.full(rxFull),
		.empty(rxEmpty)
	);

	asfcs_baud baudGen (
		.ref_clk(ref_clk),
		.reset(reset),
		.extSel(state_ff.ctrl[`ASFCS_CTRL_EXTCLK]),
		.extSerClk(extSerClk),
		.divisor(state_ff.baudDiv),
		.tick(tick)
	);

	assign char7 = state_ff.mode[`ASFCS_MODE_CHAR7];
	assign parEn = state_ff.mode[`ASFCS_MODE_PAREN];
	assign parOdd = state_ff.mode[`ASFCS_MODE_PARODD];
	assign stop2 = state_ff.mode[`ASFCS_MODE_STOP2];
	assign txEn = state_ff.ctrl[`ASFCS_CTRL_TXEN];
	assign rxEn = state_ff.ctrl[`ASFCS_CTRL_RXEN];
	assign stopEn = state_ff.ctrl[`ASFCS_CTRL_STOPEN];
	// Seven or eight data bits
	assign lastBit = char7 ? 3'h6 : 3'h7;
	// Transmitter held while the stop flag stands and the function is on
	assign txHalt = stopEn && state_ff.status[`ASFCS_ST_TXSTOP];
	assign rxLine = state_ff.ctrl[`ASFCS_CTRL_LOOP] ? state_ff.txLine : rxd;
	// Reserved bits 15 and 7 are zero
	assign fillVal = {1'h0, 7'(txCount), 1'h0, 7'(rxCount)};

	assign accWr = psel && penable && pwrite;
	assign accRd = psel && penable && !pwrite;
	assign setupRd = psel && !penable && !pwrite;
	assign addrOk = paddr inside {`ASFCS_OFS_MODE, `ASFCS_OFS_CTRL, `ASFCS_OFS_STATUS,
		`ASFCS_OFS_MASK, `ASFCS_OFS_TXDATA, `ASFCS_OFS_RXDATA, `ASFCS_OFS_FILL,
		`ASFCS_OFS_STOPCNT, `ASFCS_OFS_BAUD};

	always_comb begin
		nxt_state = state_ff;
		txPush = 1'b0;
		txPop = 1'b0;
		rxPush = 1'b0;
		rxPop = 1'b0;
		evt = 8'h00;
		clr = 8'h00;
		rxByte = 8'h00;
		rdVal = 32'h00000000;

		// Register writes; the fill count register takes no write
		if (accWr) begin
			case (paddr)
				`ASFCS_OFS_MODE: nxt_state.mode = pwdata[7:0];
				`ASFCS_OFS_CTRL: nxt_state.ctrl = pwdata[6:0];
				`ASFCS_OFS_STATUS: clr = pwdata[7:0];
				`ASFCS_OFS_MASK: nxt_state.mask = pwdata[7:0];
				`ASFCS_OFS_TXDATA: txPush = !txFull;
				`ASFCS_OFS_STOPCNT: nxt_state.stopCnt = pwdata[7:0];
				`ASFCS_OFS_BAUD: nxt_state.baudDiv = pwdata[15:0];
				default: clr = 8'h00;
			endcase
		end
		if (accRd && paddr == `ASFCS_OFS_RXDATA) begin
			rxPop = !rxEmpty;
		end

		// Read data is captured in the setup cycle
		if (setupRd) begin
			case (paddr)
				`ASFCS_OFS_MODE: rdVal = {24'h000000, state_ff.mode};
				`ASFCS_OFS_CTRL: rdVal = {25'h0000000, state_ff.ctrl};
				`ASFCS_OFS_STATUS: rdVal = {24'h000000, state_ff.status};
				`ASFCS_OFS_MASK: rdVal = {24'h000000, state_ff.mask};
				`ASFCS_OFS_RXDATA: rdVal = {24'h000000, rxHead};
				`ASFCS_OFS_FILL: rdVal = {16'h0000, fillVal};
				`ASFCS_OFS_STOPCNT: rdVal = {24'h000000, state_ff.stopCnt};
				`ASFCS_OFS_BAUD: rdVal = {16'h0000, state_ff.baudDiv};
				default: rdVal = 32'h00000000;
			endcase
			nxt_state.rdata = rdVal;
		end

		if (!stopEn) begin
			nxt_state.txSent = 8'h00;
		end

		// Transmitter: start, data LSB first, parity, stop bits
		if (tick) begin
			nxt_state.txTick = state_ff.txTick + 4'h1;
			unique case (state_ff.txState)
				asfcs_pkg::SER_IDLE: begin
					nxt_state.txLine = 1'b1;
					if (txEn && !txEmpty && !txHalt) begin
						txPop = 1'b1;
						nxt_state.txShift = txHead;
						nxt_state.txPar = ^(char7 ? {1'b0, txHead[6:0]} : txHead) ^ parOdd;
						nxt_state.txState = asfcs_pkg::SER_START;
						nxt_state.txLine = 1'b0;
						nxt_state.txTick = 4'h0;
						nxt_state.txBit = 3'h0;
					end
				end
				asfcs_pkg::SER_START: begin
					if (state_ff.txTick == `ASFCS_TICKS_LAST) begin
						nxt_state.txState = asfcs_pkg::SER_DATA;
						nxt_state.txLine = state_ff.txShift[0];
					end
				end
				asfcs_pkg::SER_DATA: begin
					if (state_ff.txTick == `ASFCS_TICKS_LAST) begin
						if (state_ff.txBit == lastBit) begin
							nxt_state.txBit = 3'h0;
							if (parEn) begin
								nxt_state.txState = asfcs_pkg::SER_PARITY;
								nxt_state.txLine = state_ff.txPar;
							end else begin
								nxt_state.txState = asfcs_pkg::SER_STOP;
								nxt_state.txLine = 1'b1;
							end
						end else begin
							nxt_state.txBit = state_ff.txBit + 3'h1;
							nxt_state.txShift = {1'b0, state_ff.txShift[7:1]};
							nxt_state.txLine = state_ff.txShift[1];
						end
					end
				end
				asfcs_pkg::SER_PARITY: begin
					if (state_ff.txTick == `ASFCS_TICKS_LAST) begin
						nxt_state.txState = asfcs_pkg::SER_STOP;
						nxt_state.txLine = 1'b1;
					end
				end
				asfcs_pkg::SER_STOP: begin
					if (state_ff.txTick == `ASFCS_TICKS_LAST) begin
						if (state_ff.txBit == {2'h0, stop2}) begin
							nxt_state.txState = asfcs_pkg::SER_IDLE;
							evt[`ASFCS_ST_TXDONE] = txEmpty;
							// Count N means N+1 frames fully sent
							if (stopEn) begin
								if (state_ff.txSent == state_ff.stopCnt) begin
									evt[`ASFCS_ST_TXSTOP] = 1'b1;
									nxt_state.txSent = 8'h00;
								end else begin
									nxt_state.txSent = state_ff.txSent + 8'h01;
								end
							end
						end else begin
							nxt_state.txBit = state_ff.txBit + 3'h1;
						end
					end
				end
				default: begin
					nxt_state.txState = asfcs_pkg::SER_IDLE;
					nxt_state.txLine = 1'b1;
				end
			endcase

			// Receiver, sampling each bit at its middle
			nxt_state.rxTick = state_ff.rxTick + 4'h1;
			unique case (state_ff.rxState)
				asfcs_pkg::SER_IDLE: begin
					if (rxEn && !rxLine) begin
						nxt_state.rxState = asfcs_pkg::SER_START;
						nxt_state.rxTick = 4'h0;
						nxt_state.rxBit = 3'h0;
						nxt_state.rxAcc = 1'b0;
						nxt_state.rxZero = 1'b1;
						nxt_state.rxParBad = 1'b0;
					end
				end
				asfcs_pkg::SER_START: begin
					if (state_ff.rxTick == `ASFCS_TICKS_MID) begin
						nxt_state.rxTick = 4'h0;
						nxt_state.rxState = rxLine ? asfcs_pkg::SER_IDLE : asfcs_pkg::SER_DATA;
					end
				end
				asfcs_pkg::SER_DATA: begin
					if (state_ff.rxTick == `ASFCS_TICKS_LAST) begin
						nxt_state.rxShift = {rxLine, state_ff.rxShift[7:1]};
						nxt_state.rxAcc = state_ff.rxAcc ^ rxLine;
						nxt_state.rxZero = state_ff.rxZero && !rxLine;
						nxt_state.rxBit = state_ff.rxBit + 3'h1;
						if (state_ff.rxBit == lastBit) begin
							nxt_state.rxState = parEn ? asfcs_pkg::SER_PARITY : asfcs_pkg::SER_STOP;
						end
					end
				end
				asfcs_pkg::SER_PARITY: begin
					if (state_ff.rxTick == `ASFCS_TICKS_LAST) begin
						nxt_state.rxParBad = state_ff.rxAcc ^ rxLine ^ parOdd;
						nxt_state.rxZero = state_ff.rxZero && !rxLine;
						nxt_state.rxState = asfcs_pkg::SER_STOP;
					end
				end
				asfcs_pkg::SER_STOP: begin
					// Only the first stop bit is checked
					if (state_ff.rxTick == `ASFCS_TICKS_LAST) begin
						nxt_state.rxState = asfcs_pkg::SER_IDLE;
						rxByte = char7 ? {1'b0, state_ff.rxShift[7:1]} : state_ff.rxShift;
						evt[`ASFCS_ST_FRAME] = !rxLine;
						evt[`ASFCS_ST_PARITY] = state_ff.rxParBad;
						evt[`ASFCS_ST_BREAK] = state_ff.rxZero && !rxLine;
						if (rxFull) begin
							evt[`ASFCS_ST_OVERRUN] = 1'b1;
						end else begin
							rxPush = 1'b1;
							evt[`ASFCS_ST_RXREADY] = 1'b1;
							evt[`ASFCS_ST_RXFULL] = (rxCount == CW'(FIFO_DEPTH - 1));
						end
					end
				end
				default: nxt_state.rxState = asfcs_pkg::SER_IDLE;
			endcase
		end

		// Sticky events; a new event wins over a clear in the same cycle
		nxt_state.status = (state_ff.status & ~clr) | evt;
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state_ff <= '0;
			state_ff.mode <= `ASFCS_RST_MODE;
			state_ff.ctrl <= `ASFCS_RST_CTRL;
			state_ff.stopCnt <= `ASFCS_RST_STOPCNT;
			state_ff.baudDiv <= `ASFCS_RST_BAUD;
			state_ff.txState <= asfcs_pkg::SER_IDLE;
			state_ff.rxState <= asfcs_pkg::SER_IDLE;
			state_ff.txLine <= 1'b1;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign prdata = state_ff.rdata;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addrOk;
	assign txd = state_ff.txLine;
	// Interrupt from any status bit, each gated by its mask bit
	assign irq = |(state_ff.status & state_ff.mask);

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);

	AST_FILL_READ: assert property (
		(setupRd && paddr == `ASFCS_OFS_FILL) |=> (prdata[14:8] == 7'($past(txCount))
			&& prdata[6:0] == 7'($past(rxCount)) && !prdata[15] && !prdata[7]))
		else $error("fill count read does not match FIFO occupancy");
	AST_TX_COUNT_MAX: assert property (txCount <= CW'(FIFO_DEPTH))
		else $error("transmit count beyond FIFO depth");
	AST_RX_COUNT_MAX: assert property (rxCount <= CW'(FIFO_DEPTH))
		else $error("receive count beyond FIFO depth");
	AST_TX_PUSH_COUNT: assert property (
		(txPush && !txPop && !state_ff.ctrl[`ASFCS_CTRL_TXCLR])
			|=> txCount == CW'($past(txCount) + 1))
		else $error("transmit count missed a push");
	AST_RX_POP_COUNT: assert property (
		(rxPop && !rxPush && !state_ff.ctrl[`ASFCS_CTRL_RXCLR])
			|=> rxCount == CW'($past(rxCount) - 1))
		else $error("receive count missed a pop");
	AST_STOP_RESET: assert property ($fell(reset) |-> state_ff.stopCnt == 8'hFF)
		else $error("stop count not 0xFF after reset");
	AST_STOP_ONLY_ENABLED: assert property (
		$rose(state_ff.status[`ASFCS_ST_TXSTOP]) |->
			($past(stopEn) && $past(state_ff.txSent) == $past(state_ff.stopCnt)))
		else $error("stop flag set without matching count");
	AST_HALT_HOLDS: assert property (
		(txHalt && state_ff.txState == asfcs_pkg::SER_IDLE)
			|=> state_ff.txState == asfcs_pkg::SER_IDLE)
		else $error("transmitter started while halted");
	AST_START_LOW: assert property (
		(state_ff.txState == asfcs_pkg::SER_IDLE ##1 state_ff.txState == asfcs_pkg::SER_START)
			|-> !txd)
		else $error("start bit not low");
	AST_STOP_HIGH: assert property (
		(state_ff.txState == asfcs_pkg::SER_STOP || state_ff.txState == asfcs_pkg::SER_IDLE)
			|-> txd)
		else $error("line low during stop or idle");
	AST_DATA_BITS: assert property (
		($past(state_ff.txState) == asfcs_pkg::SER_DATA && state_ff.txState != asfcs_pkg::SER_DATA)
			|-> ($past(state_ff.txBit) == $past(lastBit)
			&& (state_ff.txState == asfcs_pkg::SER_PARITY) == $past(parEn)))
		else $error("wrong data length or parity choice");
	AST_STOP_LEN: assert property (
		($past(state_ff.txState) == asfcs_pkg::SER_STOP && state_ff.txState != asfcs_pkg::SER_STOP)
			|-> $past(state_ff.txBit) == {2'h0, $past(stop2)})
		else $error("wrong number of stop bits");
	AST_FRAME_ERR: assert property (
		$rose(state_ff.status[`ASFCS_ST_FRAME]) |->
			($past(state_ff.rxState) == asfcs_pkg::SER_STOP && !$past(rxLine)))
		else $error("framing error without low first stop bit");

	COV_TX_FRAME: cover property (state_ff.txState == asfcs_pkg::SER_STOP
		##1 state_ff.txState == asfcs_pkg::SER_IDLE);
	COV_TX_STOP: cover property ($rose(state_ff.status[`ASFCS_ST_TXSTOP]));
	COV_RX_BYTE: cover property (rxPush);
	COV_OVERRUN: cover property ($rose(state_ff.status[`ASFCS_ST_OVERRUN]));
endmodule

// [async_serial_fifo_count_stop_tb_top.sv]
// Self-checking bench for the serial unit with fill counts and stop count
`include "asfcs_map.svh"
module async_serial_fifo_count_stop_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk, reset, psel, penable, pwrite, rxd, txd, irq, pready, pslverr, err;
	logic extSerClk = 1'b0;
	logic [7:0] paddr, modeReg, b, e;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0] txq[$];
	logic [7:0] rxq[$];
	logic [7:0] modes[4] = '{8'h00, 8'h28, 8'h78, 8'h48};
	int miscompares = 0;
	int testsRun = 0;

	asfcs_uart #(.FIFO_DEPTH(64)) uut (.ref_clk, .reset, .paddr, .psel, .penable, .pwrite,
		.pwdata, .prdata, .pready, .pslverr, .rxd, .extSerClk, .txd, .irq);
	asfcs_remote far (.ref_clk, .txd, .char7(modeReg[6]), .parEn(modeReg[5]),
		.stop2(modeReg[3]), .rxd);

	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	// External serial clock at eight times the bit rate: one edge per sample tick
	always @(posedge ref_clk) begin
		extSerClk <= ~extSerClk;
	end

	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		testsRun++;
		if (g !== x) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, x, g);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1) @(posedge ref_clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(n, x, rd);
	endtask

	task automatic waitGot(input int n);
		for (int i = 0; i < 3000 && far.got.size() < n; i++) @(posedge ref_clk);
	endtask

	task automatic drain(input int n);
		for (int i = 0; i < n; i++) begin
			e = txq.pop_front();
			chk("frame", {1'b1, modeReg[5] & (^e ^ modeReg[4]), e}, far.got.pop_front());
		end
	endtask

	task automatic pushTx(input int n);
		for (int i = 0; i < n; i++) begin
			b = 8'($urandom);
			wr(`ASFCS_OFS_TXDATA, b);
			txq.push_back(modeReg[6] ? {1'b0, b[6:0]} : b);
		end
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", testsRun, miscompares);
		if (miscompares == 0 && testsRun > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge ref_clk);
		$display("ERROR watchdog expected finish seen hang");
		miscompares++;
		summarize();
	end

	initial begin
		void'($urandom(32'h1022610c));
		reset = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		modeReg = 8'h00;
		repeat (20) @(posedge ref_clk);
		reset <= 1'b0;
		rdchk("fill reset", `ASFCS_OFS_FILL, 32'h0);
		rdchk("stopcnt reset", `ASFCS_OFS_STOPCNT, 32'hFF);
		wr(`ASFCS_OFS_FILL, 32'hFFFF);
		rdchk("fill readonly", `ASFCS_OFS_FILL, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped err", 32'h1, 32'(err));
		chk("unmapped data", 32'h0, rd);
		wr(`ASFCS_OFS_BAUD, 32'h0);
		$display("test registers done");
		// Transmit FIFO filled past its depth with the transmitter off
		for (int i = 0; i < 65; i++) begin
			b = 8'($urandom);
			wr(`ASFCS_OFS_TXDATA, b);
			if (i < 64) txq.push_back(b);
			rdchk("tx count", `ASFCS_OFS_FILL, 32'(txq.size()) << 8);
		end
		wr(`ASFCS_OFS_CTRL, 32'h4);
		wr(`ASFCS_OFS_CTRL, 32'h0);
		txq.delete();
		rdchk("tx cleared", `ASFCS_OFS_FILL, 32'h0);
		$display("test tx fill done");
		// Four formats, stop count 0 ignored while the stop function is off
		wr(`ASFCS_OFS_STOPCNT, 32'h0);
		rdchk("stopcnt rw", `ASFCS_OFS_STOPCNT, 32'h0);
		foreach (modes[m]) begin
			modeReg = modes[m];
			wr(`ASFCS_OFS_MODE, 32'(modes[m]));
			pushTx(3);
			// Second format runs from the external clock instead of the divider
			wr(`ASFCS_OFS_CTRL, (m == 1) ? 32'h21 : 32'h1);
			waitGot(3);
			drain(3);
			// Last stop cell must end before the format changes
			repeat (16) @(posedge ref_clk);
			wr(`ASFCS_OFS_CTRL, 32'h0);
		end
		$display("test formats done");
		// Stop after three bytes, then resume
		modeReg = 8'h00;
		wr(`ASFCS_OFS_MODE, 32'h0);
		wr(`ASFCS_OFS_STOPCNT, 32'h2);
		wr(`ASFCS_OFS_STATUS, 32'hFF);
		pushTx(5);
		wr(`ASFCS_OFS_CTRL, 32'h11);
		waitGot(4);
		chk("stop sent", 32'h3, 32'(far.got.size()));
		rdchk("stop left", `ASFCS_OFS_FILL, 32'h200);
		rdchk("stop flag", `ASFCS_OFS_STATUS, 32'h1);
		chk("irq masked", 32'h0, 32'(irq));
		wr(`ASFCS_OFS_MASK, 32'h1);
		@(negedge ref_clk);
		chk("irq raised", 32'h1, 32'(irq));
		drain(3);
		wr(`ASFCS_OFS_STATUS, 32'h1);
		@(negedge ref_clk);
		chk("irq cleared", 32'h0, 32'(irq));
		waitGot(2);
		drain(2);
		rdchk("stop empty", `ASFCS_OFS_FILL, 32'h0);
		wr(`ASFCS_OFS_CTRL, 32'h0);
		wr(`ASFCS_OFS_MASK, 32'h0);
		$display("test stop count done");
		// Receive FIFO overfilled, then drained
		wr(`ASFCS_OFS_STATUS, 32'hFF);
		wr(`ASFCS_OFS_CTRL, 32'h2);
		for (int i = 0; i < 65; i++) begin
			b = 8'($urandom);
			far.send(b, 1'b0);
			if (i < 64) rxq.push_back(b);
		end
		rdchk("rx full count", `ASFCS_OFS_FILL, 32'h40);
		apb(1'b0, `ASFCS_OFS_STATUS, 32'h0);
		chk("rx flags", 32'h38, rd & 32'h7F);
		while (rxq.size() > 0) begin
			rdchk("rx data", `ASFCS_OFS_RXDATA, 32'(rxq.pop_front()));
			rdchk("rx count", `ASFCS_OFS_FILL, 32'(rxq.size()));
		end
		// Framing, break and parity faults
		wr(`ASFCS_OFS_STATUS, 32'hFF);
		far.send(8'hA5, 1'b1);
		apb(1'b0, `ASFCS_OFS_STATUS, 32'h0);
		chk("framing", 32'h22, rd & 32'h7F);
		wr(`ASFCS_OFS_STATUS, 32'hFF);
		far.send(8'h00, 1'b1);
		apb(1'b0, `ASFCS_OFS_STATUS, 32'h0);
		chk("break", 32'h62, rd & 32'h7F);
		wr(`ASFCS_OFS_MODE, 32'h20);
		wr(`ASFCS_OFS_STATUS, 32'hFF);
		far.send(8'hA5, 1'b0);
		// Stop bit is taken as parity, so the frame ends one cell after the send
		repeat (16) @(posedge ref_clk);
		apb(1'b0, `ASFCS_OFS_STATUS, 32'h0);
		chk("parity", 32'h24, rd & 32'h7F);
		$display("test receive done");
		// Loopback: receiver fed from the transmit line
		wr(`ASFCS_OFS_MODE, 32'h0);
		wr(`ASFCS_OFS_CTRL, 32'h8);
		wr(`ASFCS_OFS_CTRL, 32'h43);
		pushTx(1);
		waitGot(1);
		drain(1);
		repeat (16) @(posedge ref_clk);
		rdchk("loop data", `ASFCS_OFS_RXDATA, 32'(b));
		wr(`ASFCS_OFS_CTRL, 32'h0);
		$display("test loopback done");
		summarize();
	end
endmodule
